//--- rtl/neg_seq_pkg.sv
package neg_seq_pkg;
	localparam int CLK_NS          = 10;
	localparam int TICK_NS         = 1000000;
	localparam int TICK_CYC        = TICK_NS / CLK_NS;
	localparam int TICKS_PER_TENTH = 100;
	localparam int PCT_SCALE       = 1000;
	localparam int PCT_BITS        = 11;
	localparam int REL_NUM         = 9;
	localparam int REL_DEN         = 10;
	localparam logic [5:0] A_CTRL     = 6'h00;
	localparam logic [5:0] A_GNOM     = 6'h04;
	localparam logic [5:0] A_KCONST   = 6'h08;
	localparam logic [5:0] A_COOL     = 6'h0C;
	localparam logic [5:0] A_WARN_THR = 6'h10;
	localparam logic [5:0] A_INT_THR  = 6'h14;
	localparam logic [5:0] A_WARN_DLY = 6'h18;
	localparam logic [5:0] A_MIN_DLY  = 6'h1C;
	localparam logic [5:0] A_STATUS   = 6'h20;
	localparam logic [5:0] A_INTEGRAL = 6'h24;
	localparam logic [5:0] A_IRQ_STAT = 6'h28;
	localparam logic [5:0] A_IRQ_MASK = 6'h2C;
	localparam int CTRL_OPER  = 0;
	localparam int CTRL_SONLY = 1;
	localparam logic [15:0] RST_GNOM     = 16'h03E8;
	localparam logic [15:0] RST_KCONST   = 16'h0064;
	localparam logic [15:0] RST_COOL     = 16'h03E8;
	localparam logic [15:0] RST_WARN_THR = 16'h0028;
	localparam logic [15:0] RST_INT_THR  = 16'h0032;
	localparam logic [15:0] RST_WARN_DLY = 16'h03E8;
	localparam logic [15:0] RST_MIN_DLY  = 16'h0064;
	typedef struct packed {
		logic        oper;
		logic        sonly;
		logic [15:0] gnom;
		logic [15:0] kconst;
		logic [15:0] cool;
		logic [15:0] warn_thr;
		logic [15:0] int_thr;
		logic [15:0] warn_dly;
		logic [15:0] min_dly;
	} settings_s;
	typedef struct packed {
		logic wsg;
		logic wst;
		logic gtr;
		logic gst;
	} flags_s;
	typedef enum logic {DIV_IDLE = 1'b0, DIV_RUN = 1'b1} div_state_e;
endpackage : neg_seq_pkg

//--- rtl/neg_seq_thermal_integrator.sv
`timescale 1ns/1ps
module neg_seq_thermal_integrator #(
	parameter int TICK_CYCLES = neg_seq_pkg::TICK_CYC
) (
	input  wire logic        sys_clk_i,            // 100 MHz clock
	input  wire logic        rst_i,                // Sync reset, high
	input  wire logic        ce_i,                 // Clock enable
	input  wire logic [15:0] i2_mag_i,             // I2, 0.1 % of CT
	input  wire logic        i2_valid_i,           // New I2 value
	input  wire logic        function_block_i,     // Disable from user logic
	input  wire logic [5:0]  avs_address_i,        // Byte address
	input  wire logic        avs_read_i,           // Read request
	input  wire logic        avs_write_i,          // Write request
	input  wire logic [31:0] avs_writedata_i,      // Write data
	input  wire logic [3:0]  avs_byteenable_i,     // Byte enables
	output logic      [31:0] avs_readdata_o,       // Read data
	output logic             avs_waitrequest_o,    // Wait request
	output logic             general_start_flag_o, // Integrating
	output logic             general_trip_flag_o,  // Trip
	output logic             warning_start_flag_o, // Warning start
	output logic             warning_signal_flag_o,// Warning signal
	output logic             irq_o                 // Level interrupt
);
	import neg_seq_pkg::*;

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction : merge16

	settings_s   set_reg;
	flags_s      flags_reg;
	flags_s      flags_next;
	div_state_e  div_reg;
	logic [15:0] i2_reg;
	logic [31:0] tick_cnt_reg;
	logic [63:0] integ_reg;
	logic [63:0] integ_next;
	logic [15:0] start_cnt_reg;
	logic [15:0] warn_cnt_reg;
	logic        trip_reg;
	logic        ack_reg;
	logic [31:0] rdata_reg;
	logic [3:0]  irq_stat_reg;
	logic [3:0]  irq_mask_reg;
	logic [79:0] div_num_reg;
	logic [63:0] div_den_reg;
	logic [3:0]  div_cnt_reg;
	logic [PCT_BITS-1:0] quo_reg;
	logic [PCT_BITS-1:0] pct_reg;

	// Bus handshake: one wait cycle, then answer
	wire req      = avs_read_i | avs_write_i;
	wire wr_go    = ce_i & avs_write_i & ack_reg;
	wire param_wr = wr_go & (avs_address_i <= A_MIN_DLY);
	wire w1c_wr   = wr_go & (avs_address_i == A_IRQ_STAT);
	assign avs_waitrequest_o = req & ~ack_reg;
	assign avs_readdata_o    = rdata_reg;

	wire tick = ce_i & (tick_cnt_reg == 32'(TICK_CYCLES - 1));
	wire enabled = set_reg.oper & ~function_block_i;

	// Thresholds relative to rated current, all in 0.1 % units
	wire [31:0] i2_scaled  = 32'(i2_reg) * 32'(PCT_SCALE);
	wire [31:0] int_level  = 32'(set_reg.int_thr) * 32'(set_reg.gnom);
	wire [31:0] warn_level = 32'(set_reg.warn_thr) * 32'(set_reg.gnom);
	wire above_int  = i2_scaled > int_level;
	wire above_warn = i2_scaled > warn_level;
	wire heat = enabled & above_int;

	// Scaled integral: heating adds I2^2*Tcool, cooling removes In^2*K,
	// full scale is In^2*K*Tcool, so no divider sits in the loop
	wire [31:0] k_ticks    = 32'(set_reg.kconst) * 32'(TICKS_PER_TENTH);
	wire [31:0] cool_ticks = 32'(set_reg.cool) * 32'(TICKS_PER_TENTH);
	wire [31:0] gnom_sq    = 32'(set_reg.gnom) * 32'(set_reg.gnom);
	wire [31:0] i2_sq      = 32'(i2_reg) * 32'(i2_reg);
	wire [63:0] heat_inc   = 64'(i2_sq) * 64'(cool_ticks);
	wire [63:0] cool_dec   = 64'(gnom_sq) * 64'(k_ticks);
	wire [63:0] full       = cool_dec * 64'(cool_ticks);
	wire [63:0] two_full   = {full[62:0], 1'b0};
	wire [63:0] heat_sum   = integ_reg + heat_inc;
	wire [67:0] rel_lhs    = 68'(integ_reg) * 68'(REL_DEN);
	wire [67:0] rel_rhs    = 68'(full) * 68'(REL_NUM);
	wire below_rel  = rel_lhs < rel_rhs;
	wire at_full    = integ_reg >= full;
	wire delay_done = start_cnt_reg >= set_reg.min_dly;
	wire warn_done  = warn_cnt_reg >= set_reg.warn_dly;

	always_comb
	begin
		integ_next = integ_reg;
		if (param_wr)
			integ_next = '0;
		else if (tick && heat)
			integ_next = (heat_sum > two_full) ? two_full : heat_sum;
		else if (tick)
			integ_next = (integ_reg > cool_dec) ?
				integ_reg - cool_dec : '0;
	end

	always_comb
	begin
		flags_next.gst = heat;
		flags_next.gtr = trip_reg & enabled & ~set_reg.sonly;
		flags_next.wst = enabled & above_warn;
		flags_next.wsg = enabled & above_warn & warn_done;
	end

	wire [3:0] events  = flags_next & ~flags_reg;
	wire [3:0] w1c     = w1c_wr ? avs_writedata_i[3:0] : 4'h0;

	wire [31:0] rd_mux =
		(avs_address_i == A_CTRL)     ? {30'h0, set_reg.sonly, set_reg.oper} :
		(avs_address_i == A_GNOM)     ? {16'h0, set_reg.gnom} :
		(avs_address_i == A_KCONST)   ? {16'h0, set_reg.kconst} :
		(avs_address_i == A_COOL)     ? {16'h0, set_reg.cool} :
		(avs_address_i == A_WARN_THR) ? {16'h0, set_reg.warn_thr} :
		(avs_address_i == A_INT_THR)  ? {16'h0, set_reg.int_thr} :
		(avs_address_i == A_WARN_DLY) ? {16'h0, set_reg.warn_dly} :
		(avs_address_i == A_MIN_DLY)  ? {16'h0, set_reg.min_dly} :
		(avs_address_i == A_STATUS)   ? {28'h0, flags_reg} :
		(avs_address_i == A_INTEGRAL) ? {21'h0, pct_reg} :
		(avs_address_i == A_IRQ_STAT) ? {28'h0, irq_stat_reg} :
		(avs_address_i == A_IRQ_MASK) ? {28'h0, irq_mask_reg} : 32'h0;

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0;
		end
		else if (ce_i)
		begin
			ack_reg <= req & ~ack_reg;
			if (req && !ack_reg)
				rdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			set_reg      <= '{1'b0, 1'b0, RST_GNOM, RST_KCONST, RST_COOL,
				RST_WARN_THR, RST_INT_THR, RST_WARN_DLY, RST_MIN_DLY};
			irq_mask_reg <= 4'h0;
		end
		else if (wr_go)
		begin
			case (avs_address_i)
				A_CTRL:
				begin
					if (avs_byteenable_i[0])
					begin
						set_reg.oper  <= avs_writedata_i[CTRL_OPER];
						set_reg.sonly <= avs_writedata_i[CTRL_SONLY];
					end
				end
				A_GNOM:     set_reg.gnom <= merge16(set_reg.gnom,
					avs_writedata_i, avs_byteenable_i);
				A_KCONST:   set_reg.kconst <= merge16(set_reg.kconst,
					avs_writedata_i, avs_byteenable_i);
				A_COOL:     set_reg.cool <= merge16(set_reg.cool,
					avs_writedata_i, avs_byteenable_i);
				A_WARN_THR: set_reg.warn_thr <= merge16(set_reg.warn_thr,
					avs_writedata_i, avs_byteenable_i);
				A_INT_THR:  set_reg.int_thr <= merge16(set_reg.int_thr,
					avs_writedata_i, avs_byteenable_i);
				A_WARN_DLY: set_reg.warn_dly <= merge16(set_reg.warn_dly,
					avs_writedata_i, avs_byteenable_i);
				A_MIN_DLY:  set_reg.min_dly <= merge16(set_reg.min_dly,
					avs_writedata_i, avs_byteenable_i);
				A_IRQ_MASK:
				begin
					if (avs_byteenable_i[0])
						irq_mask_reg <= avs_writedata_i[3:0];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			i2_reg       <= 16'h0;
			tick_cnt_reg <= 32'h0;
			integ_reg    <= 64'h0;
		end
		else if (ce_i)
		begin
			if (i2_valid_i)
				i2_reg <= i2_mag_i;
			tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
			integ_reg    <= integ_next;
		end
	end

	// Time since start and warning time, in 1 ms ticks, saturating
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			start_cnt_reg <= 16'h0;
			warn_cnt_reg  <= 16'h0;
		end
		else if (ce_i)
		begin
			if (!heat)
				start_cnt_reg <= 16'h0;
			else if (tick && start_cnt_reg != 16'hFFFF)
				start_cnt_reg <= start_cnt_reg + 16'h1;
			if (!(enabled && above_warn))
				warn_cnt_reg <= 16'h0;
			else if (tick && warn_cnt_reg != 16'hFFFF)
				warn_cnt_reg <= warn_cnt_reg + 16'h1;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			trip_reg <= 1'b0;
		else if (ce_i)
		begin
			if (!enabled || below_rel)
				trip_reg <= 1'b0;
			else if (heat && at_full && delay_done)
				trip_reg <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			flags_reg    <= '0;
			irq_stat_reg <= 4'h0;
		end
		else if (ce_i)
		begin
			flags_reg    <= flags_next;
			irq_stat_reg <= (irq_stat_reg & ~w1c) | events;
		end
	end
	assign irq_o = |(irq_stat_reg & irq_mask_reg);
	assign general_start_flag_o  = flags_reg.gst;
	assign general_trip_flag_o   = flags_reg.gtr;
	assign warning_start_flag_o  = flags_reg.wst;
	assign warning_signal_flag_o = flags_reg.wsg;

	// Serial divider turns the scaled integral into 0.1 % units each tick
	wire [79:0] div_trial = 80'(div_den_reg) << div_cnt_reg;
	wire        div_fit   = div_num_reg >= div_trial;
	wire [PCT_BITS-1:0] quo_bit = PCT_BITS'(1) << div_cnt_reg;

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			div_reg     <= DIV_IDLE;
			div_num_reg <= 80'h0;
			div_den_reg <= 64'h0;
			div_cnt_reg <= 4'h0;
			quo_reg     <= '0;
			pct_reg     <= '0;
		end
		else if (ce_i)
		begin
			case (div_reg)
				DIV_IDLE:
				begin
					if (tick)
					begin
						div_num_reg <= 80'(integ_reg) * 80'(PCT_SCALE);
						div_den_reg <= full;
						div_cnt_reg <= 4'(PCT_BITS - 1);
						quo_reg     <= '0;
						div_reg     <= DIV_RUN;
					end
				end
				DIV_RUN:
				begin
					if (div_fit)
						div_num_reg <= div_num_reg - div_trial;
					if (div_cnt_reg == 4'h0)
					begin
						pct_reg <= div_fit ? quo_reg | quo_bit : quo_reg;
						div_reg <= DIV_IDLE;
					end
					else
					begin
						quo_reg     <= div_fit ? quo_reg | quo_bit : quo_reg;
						div_cnt_reg <= div_cnt_reg - 4'h1;
					end
				end
				default: div_reg <= DIV_IDLE;
			endcase
		end
	end

	a_trip_full_delay: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(trip_reg) |-> $past(at_full) && $past(delay_done))
		else $error("trip set before full integral or minimum delay");
	a_integral_clamp: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		integ_reg <= two_full)
		else $error("integral above clamp");
	a_trip_release: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i && trip_reg && below_rel |=> !trip_reg)
		else $error("trip held below release level");
	a_param_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		param_wr |=> integ_reg == 64'h0)
		else $error("integral not cleared on parameter load");
	a_cool_linear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		tick && !heat && !param_wr && integ_reg > cool_dec
		|=> integ_reg == $past(integ_reg) - $past(cool_dec))
		else $error("cooling step wrong");
	a_heat_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		tick && heat && !param_wr && heat_sum <= two_full
		|=> integ_reg == $past(integ_reg) + $past(heat_inc))
		else $error("heating step wrong");
	a_rise_needs_heat: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		integ_reg > $past(integ_reg) |-> $past(heat))
		else $error("integral rose without start");
	a_off_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!enabled ##1 !enabled |-> flags_reg == '0)
		else $error("outputs active while disabled");
	a_start_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		set_reg.sonly ##1 set_reg.sonly |-> !general_trip_flag_o)
		else $error("trip issued in start-only mode");
	a_warn_delay: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(warning_signal_flag_o) |-> $past(warn_cnt_reg)
		>= $past(set_reg.warn_dly))
		else $error("warning signal before delay");
	a_gen_start: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ce_i |=> general_start_flag_o == $past(heat))
		else $error("general start does not follow integration");
endmodule : neg_seq_thermal_integrator

//--- verification/i2_source.sv
`timescale 1ns/1ps
module i2_source (
	input  wire logic        sys_clk_i,  // Clock
	input  wire logic        rst_i,      // Sync reset, high
	input  wire logic [15:0] level_i,    // Current to report
	output logic      [15:0] i2_mag_o,   // I2 magnitude
	output logic             i2_valid_o  // New value strobe
);
	logic [1:0] phase_reg;
	// Between strobes the data lines toggle so stale values match the strobed value in only one of three cycles
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			phase_reg  <= 2'h0;
			i2_valid_o <= 1'b0;
			i2_mag_o   <= 16'h0000;
		end
		else
		begin
			phase_reg  <= phase_reg + 2'h1;
			i2_valid_o <= (phase_reg == 2'h3);
			i2_mag_o   <= (phase_reg == 2'h3) ? level_i : ~i2_mag_o;
		end
	end
endmodule : i2_source

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import neg_seq_pkg::*;
	localparam int TK = 20;
	localparam int GN = 1000;
	localparam int KT = 500;
	localparam int CT = 500;
	localparam int MD = 100;
	logic        sys_clk_i, rst_i, blk, rd, wr, wrq, irq, vld;
	logic [5:0]  adr;
	logic [31:0] wdat, rdat, q;
	logic [15:0] lvl, mag;
	flags_s      fl;
	int          n_errors, samples_checked, cyc, seed, t, i;
	logic [5:0]  ra [8] = '{A_CTRL, A_GNOM, A_KCONST, A_COOL, A_WARN_THR,
		A_INT_THR, A_WARN_DLY, A_MIN_DLY};
	logic [15:0] rv [8] = '{16'h0000, RST_GNOM, RST_KCONST, RST_COOL,
		RST_WARN_THR, RST_INT_THR, RST_WARN_DLY, RST_MIN_DLY};

	i2_source src (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .level_i(lvl),
		.i2_mag_o(mag), .i2_valid_o(vld));
	neg_seq_thermal_integrator #(.TICK_CYCLES(TK)) dut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.i2_mag_i(mag), .i2_valid_i(vld), .function_block_i(blk),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wrq),
		.general_start_flag_o(fl.gst), .general_trip_flag_o(fl.gtr),
		.warning_start_flag_o(fl.wst), .warning_signal_flag_o(fl.wsg),
		.irq_o(irq));

	initial
	begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	task print_verdict;
		$display("errors=%0d compares=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict

	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (cyc == 50000)
		begin
			n_errors++;
			print_verdict;
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// Integral reading may lag or lead by a tick or two
	task near(input logic [31:0] g, input int e);
		samples_checked++;
		if (^g === 1'bx || int'(g) - e > 6 || e - int'(g) > 6)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : near

	// Request held until an edge samples waitrequest low; data taken there
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		@(posedge sys_clk_i);
		while (wrq !== 1'b0)
			@(posedge sys_clk_i);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge sys_clk_i);
	endtask : bus

	task tick(input int n);
		repeat (n * TK) @(posedge sys_clk_i);
	endtask : tick

	function int trip_ticks(input int i2, input int md);
		int f;
		f = (GN * GN * KT + i2 * i2 - 1) / (i2 * i2);
		return (f > md) ? f : md;
	endfunction : trip_ticks

	function int heat(input int n, input int i2);
		int h;
		h = n * i2 * i2 / (GN * GN * KT / 1000);
		return (h > 2000) ? 2000 : h;
	endfunction : heat

	initial
	begin
		seed = 61126;
		rst_i = 1'b1;
		{blk, rd, wr, adr, wdat, lvl} = '0;
		repeat (5) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		for (i = 0; i < 8; i++)
		begin
			bus(1'b0, ra[i], 32'h0);
			chk(q, {16'h0000, rv[i]});
		end
		bus(1'b0, A_IRQ_MASK, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, 6'h30, 32'hFFFF);
		bus(1'b0, 6'h30, 32'h0);
		chk(q, 32'h0);
		lvl <= 16'h0FA0;
		tick(20);
		chk(32'(fl), 32'h0);
		bus(1'b1, A_KCONST, 32'h5);
		bus(1'b1, A_COOL, 32'h5);
		bus(1'b1, A_WARN_DLY, 32'h3C);
		bus(1'b1, A_CTRL, 32'h1);
		t = $random(seed);
		lvl <= 16'(41 + (t & 7));
		tick(10);
		chk({fl.gst, fl.wst}, 32'h1);
		tick(40);
		chk(fl.wsg, 32'h0);
		tick(20);
		chk(fl.wsg, 32'h1);
		lvl <= 16'h0FA0;
		t = trip_ticks(4000, MD);
		tick(t - 5);
		chk({fl.gst, fl.gtr}, 32'h2);
		tick(10);
		chk(32'(fl), 32'hF);
		bus(1'b0, A_STATUS, 32'h0);
		chk(q, 32'hF);
		bus(1'b0, A_IRQ_STAT, 32'h0);
		chk(q, 32'hF);
		chk(irq, 32'h0);
		bus(1'b1, A_IRQ_MASK, 32'h2);
		chk(irq, 32'h1);
		bus(1'b1, A_IRQ_STAT, 32'hF);
		chk(irq, 32'h0);
		blk <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		chk(32'(fl), 32'h0);
		blk <= 1'b0;
		lvl <= 16'h0000;
		bus(1'b0, A_INTEGRAL, 32'h0);
		near(q, 2000);
		bus(1'b1, A_GNOM, GN);
		tick(2);
		bus(1'b0, A_INTEGRAL, 32'h0);
		near(q, 0);
		bus(1'b1, A_CTRL, 32'h3);
		lvl <= 16'h0FA0;
		tick(t + 10);
		chk({fl.gst, fl.gtr}, 32'h2);
		lvl <= 16'h0000;
		bus(1'b1, A_CTRL, 32'h1);
		lvl <= 16'(GN);
		t = trip_ticks(GN, MD);
		tick(t - 5);
		chk(fl.gtr, 32'h0);
		bus(1'b0, A_INTEGRAL, 32'h0);
		near(q, heat(t - 5, GN));
		tick(10);
		chk(fl.gtr, 32'h1);
		tick(600);
		bus(1'b0, A_INTEGRAL, 32'h0);
		near(q, heat(t + 610, GN));
		lvl <= 16'h0000;
		tick(250);
		bus(1'b0, A_INTEGRAL, 32'h0);
		near(q, 2000 - 250 * 1000 / CT);
		tick((2000 - 900) * CT / 1000 - 255);
		chk(fl.gtr, 32'h1);
		tick(10);
		chk(fl.gtr, 32'h0);
		print_verdict;
	end
endmodule : tb_top
